// ### design/dca_decoder.sv
// top: command and address decoder with bank state, mode register, strobe and mask control
module dca_decoder
  import dca_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire dca_pins_t pins,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe,
  output dca_dec_t dec,
  output logic [DCA_BANKS-1:0] bank_open,
  output logic [DCA_BANKS-1:0] bank_pend_pre,
  output logic tdqs_en,
  output logic tdqs_term,
  output logic wr_byte_en,
  output logic wr_strobe
);
  localparam int PW = $bits(dca_pins_t);

  if (DCA_BANKS != (1 << DCA_BA_W))
  begin : g_bank_chk
    $error("bank count must match bank address width");
  end

  dca_pins_t sp;
  logic dqs_s;

  dca_sync #(.WIDTH(PW + 1)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .d({pins, dqs_i}),
    .q({sp, dqs_s})
  );

  typedef struct packed {
    dca_dec_t dec;
    logic [DCA_BANKS-1:0] open;
    logic [DCA_BANKS-1:0] pend;
    logic [DCA_ADDR_W-1:0] mr1;
    logic dqs_o;
    logic dqs_oe;
    logic byte_en;
    logic wstb;
    logic dqs_prev;
  } dca_st_t;

  dca_st_t st_q;
  dca_st_t st_d;
  dca_cmd_t cmd;

  // command decode from registered pins, sampled on the rising edge only
  always_comb
  begin
    cmd = DCA_CMD_NONE;
    if (!sp.cs_n) // cs high masks every command
    begin
      unique case ({sp.ras_n, sp.cas_n, sp.we_n})
        3'b111: cmd = DCA_CMD_NOP;
        3'b011: cmd = DCA_CMD_ACT;
        3'b010: cmd = DCA_CMD_PRE;
        3'b101: cmd = DCA_CMD_RD;
        3'b100: cmd = DCA_CMD_WR;
        3'b000: cmd = DCA_CMD_MRS;
        default: cmd = DCA_CMD_OTHER;
      endcase
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.dec = '0;
    st_d.dec.cmd = cmd;
    st_d.dec.bank = sp.ba;
    st_d.wstb = 1'b0;
    st_d.dqs_prev = dqs_s;
    st_d.pend = '0;
    unique case (cmd)
      DCA_CMD_ACT:
      begin
        st_d.dec.row = sp.addr;
        st_d.open[sp.ba] = 1'b1;
      end
      DCA_CMD_PRE:
      begin
        st_d.dec.pre_all = sp.addr[DCA_AP_BIT];
        if (sp.addr[DCA_AP_BIT])
          st_d.open = '0;
        else
          st_d.open[sp.ba] = 1'b0;
      end
      DCA_CMD_RD, DCA_CMD_WR:
      begin
        st_d.dec.col = sp.addr[DCA_COL_W-1:0];
        st_d.dec.auto_pre = sp.addr[DCA_AP_BIT];
        st_d.dec.burst_full = sp.addr[DCA_BC_BIT];
        if (sp.addr[DCA_AP_BIT])
        begin
          st_d.pend[sp.ba] = 1'b1;
          st_d.open[sp.ba] = 1'b0;
        end
      end
      DCA_CMD_MRS:
      begin
        st_d.dec.opcode = sp.addr;
        if (sp.ba == DCA_MR1_SEL)
          st_d.mr1 = sp.addr;
      end
      default:
      begin
      end
    endcase
    // strobe driven out only in a read data phase
    st_d.dqs_oe = sp.data_phase && !sp.write_phase;
    st_d.dqs_o = st_d.dqs_oe ? !st_q.dqs_o : 1'b0;
    // write beat: capture on strobe edge, mask unless termination strobe on
    if (sp.data_phase && sp.write_phase && (dqs_s != st_q.dqs_prev))
    begin
      st_d.wstb = 1'b1;
      st_d.byte_en = st_q.mr1[DCA_TDQS_BIT] ? 1'b1 : !sp.dm;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= '0;
      st_q.open <= DCA_BANK_RST;
      st_q.mr1 <= DCA_MR_RST;
      // strobe history matches the synchroniser reset level, no false beat
      st_q.dqs_prev <= DCA_STB_RST;
    end
    else
      st_q <= st_d;
  end

  assign dec = st_q.dec;
  assign bank_open = st_q.open;
  assign bank_pend_pre = st_q.pend;
  assign tdqs_en = st_q.mr1[DCA_TDQS_BIT];
  assign tdqs_term = st_q.mr1[DCA_TDQS_BIT];
  assign wr_byte_en = st_q.byte_en;
  assign wr_strobe = st_q.wstb;
  assign dqs_o = st_q.dqs_o;
  assign dqs_oe = st_q.dqs_oe;

  property p_cs_mask;
    @(posedge mclk) disable iff (reset) sp.cs_n |=> dec.cmd == DCA_CMD_NONE;
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command not masked by chip select");

  property p_act_open;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_ACT |=> bank_open[$past(sp.ba)] && dec.row == $past(sp.addr);
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank");

  property p_pre_all;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_PRE && sp.addr[DCA_AP_BIT] |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_pre_one;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_PRE && !sp.addr[DCA_AP_BIT] |=> !bank_open[$past(sp.ba)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge missed its bank");

  property p_col;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_RD |=> dec.col == $past(sp.addr[DCA_COL_W-1:0]) && dec.burst_full == $past(sp.addr[DCA_BC_BIT]);
  endproperty
  a_col: assert property (p_col) else $error("column or burst chop wrong");

  property p_ap;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_WR |=> dec.auto_pre == $past(sp.addr[DCA_AP_BIT]);
  endproperty
  a_ap: assert property (p_ap) else $error("auto-precharge flag wrong");

  property p_nop;
    @(posedge mclk) disable iff (reset) cmd == DCA_CMD_NOP |=> $stable(bank_open);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed bank state");

  property p_mask;
    @(posedge mclk) disable iff (reset) wr_strobe && !$past(tdqs_en) && $past(sp.dm) |-> !wr_byte_en;
  endproperty
  a_mask: assert property (p_mask) else $error("masked byte was written");

  property p_dqs_dir;
    @(posedge mclk) disable iff (reset) dqs_oe |-> $past(sp.data_phase) && !$past(sp.write_phase);
  endproperty
  a_dqs_dir: assert property (p_dqs_dir) else $error("strobe driven outside read");

  sequence s_rd_ap;
    cmd == DCA_CMD_RD && sp.addr[DCA_AP_BIT];
  endsequence

  property p_rd_ap;
    @(posedge mclk) disable iff (reset) s_rd_ap |=> bank_pend_pre[$past(sp.ba)] && !bank_open[$past(sp.ba)];
  endproperty
  a_rd_ap: assert property (p_rd_ap) else $error("read auto-precharge left bank open");

  sequence s_wr_beat;
    sp.data_phase && sp.write_phase && (dqs_s != st_q.dqs_prev);
  endsequence

  property p_tdqs_mask;
    @(posedge mclk) disable iff (reset) s_wr_beat ##0 tdqs_en |=> wr_strobe && wr_byte_en;
  endproperty
  a_tdqs_mask: assert property (p_tdqs_mask) else $error("mask honoured with termination strobe on");

  property p_mr1;
    @(posedge mclk) disable iff (reset)
      cmd == DCA_CMD_MRS && sp.ba == DCA_MR1_SEL |=> tdqs_en == $past(sp.addr[DCA_TDQS_BIT]);
  endproperty
  a_mr1: assert property (p_mr1) else $error("mode register 1 bit not taken");

  property p_bank;
    @(posedge mclk) disable iff (reset)
      cmd inside {DCA_CMD_ACT, DCA_CMD_PRE, DCA_CMD_RD, DCA_CMD_WR} |=> dec.bank == $past(sp.ba);
  endproperty
  a_bank: assert property (p_bank) else $error("bank address not carried");

  property p_rd_code;
    @(posedge mclk) disable iff (reset)
      !sp.cs_n && sp.ras_n && !sp.cas_n && sp.we_n |=> dec.cmd == DCA_CMD_RD;
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("read code not decoded");
endmodule // dca_decoder

// ### design/dca_pkg.sv
// package: command decoder constants, types and commands
package dca_pkg;
  localparam int DCA_BANKS = 8;
  localparam int DCA_BA_W = 3;
  localparam int DCA_ADDR_W = 13;
  localparam int DCA_COL_W = 10;
  localparam int DCA_AP_BIT = 10;
  localparam int DCA_BC_BIT = 12;
  localparam int DCA_TDQS_BIT = 11;
  localparam int DCA_SYNC_STAGES = 3;
  localparam logic [2:0] DCA_MR1_SEL = 3'h1;
  localparam logic [7:0] DCA_BANK_RST = 8'h00;
  localparam logic [DCA_ADDR_W-1:0] DCA_MR_RST = 13'h0000;
  localparam logic DCA_STB_RST = 1'b1;

  typedef enum logic [2:0] {
    DCA_CMD_NONE,
    DCA_CMD_NOP,
    DCA_CMD_ACT,
    DCA_CMD_PRE,
    DCA_CMD_RD,
    DCA_CMD_WR,
    DCA_CMD_MRS,
    DCA_CMD_OTHER
  } dca_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [DCA_BA_W-1:0] ba;
    logic [DCA_ADDR_W-1:0] addr;
    logic dm;
    logic data_phase;
    logic write_phase;
  } dca_pins_t;

  typedef struct packed {
    dca_cmd_t cmd;
    logic [DCA_BA_W-1:0] bank;
    logic [DCA_ADDR_W-1:0] row;
    logic [DCA_COL_W-1:0] col;
    logic [DCA_ADDR_W-1:0] opcode;
    logic auto_pre;
    logic pre_all;
    logic burst_full;
  } dca_dec_t;
endpackage

// ### design/dca_sync.sv
// three-stage synchroniser for pin inputs, change taken when stages 2 and 3 agree
module dca_sync
  import dca_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1)
  begin : g_width_chk
    $error("dca_sync width must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } dca_sync_st_t;

  dca_sync_st_t st_q;
  dca_sync_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
        st_d.q[i] = st_q.s3[i];
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st_q <= '1;
    else
      st_q <= st_d;
  end

  assign q = st_q.q;
endmodule // dca_sync

// ### bench/dca_ctl_model.sv
// controller model driving command pins and write strobe
module dca_ctl_model
  import dca_pkg::*;
(
  input wire logic mclk,
  output dca_pins_t pins,
  output logic dqs_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    dqs_i = 1'b0;
  end
  // command held for five edges, bank with it
  task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [12:0] a);
    @(posedge mclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
    pins.ba <= ba;
    pins.addr <= a;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  // deselect, released lines show the inverse
  task automatic idle();
    @(posedge mclk);
    pins.cs_n <= 1'b1;
    pins.ba <= ~pins.ba;
    pins.addr <= ~pins.addr;
    pins.data_phase <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  // data phase; strobe driven here only for writes
  task automatic beat(input logic w, input logic m);
    @(posedge mclk);
    pins.data_phase <= 1'b1;
    pins.write_phase <= w;
    pins.dm <= m;
    dqs_i <= dqs_i ^ w;
    repeat (5) @(posedge mclk);
    #1;
  endtask
endmodule // dca_ctl_model

// ### bench/tb.sv
// testbench for the command decoder
module tb
  import dca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic reset;
  dca_pins_t pins;
  logic dqs_i, dqs_o, dqs_oe, tdqs_en, tdqs_term, wr_byte_en, wr_strobe;
  dca_dec_t dec;
  logic [7:0] bank_open, bank_pend_pre;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  dca_ctl_model i_ctl (.mclk(mclk), .pins(pins), .dqs_i(dqs_i));
  dca_decoder i_dut (.mclk(mclk), .reset(reset), .pins(pins), .dqs_i(dqs_i), .dqs_o(dqs_o),
    .dqs_oe(dqs_oe), .dec(dec), .bank_open(bank_open), .bank_pend_pre(bank_pend_pre),
    .tdqs_en(tdqs_en), .tdqs_term(tdqs_term), .wr_byte_en(wr_byte_en), .wr_strobe(wr_strobe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_act();
    i_ctl.issue(4'h3, 3'h2, 13'h1abc);
    check(16'(dec.cmd), 16'(DCA_CMD_ACT));
    check(16'(dec.row), 16'h1abc);
    check(16'(dec.bank), 16'h0002);
    check(16'(bank_open), 16'h0004);
    i_ctl.idle();
    check(16'(dec.cmd), 16'(DCA_CMD_NONE));
    i_ctl.issue(4'hb, 3'h5, 13'h0000);
    check(16'(dec.cmd), 16'(DCA_CMD_NONE));
    check(16'(bank_open), 16'h0004);
    $display("test act done");
  endtask
  task automatic t_rw();
    i_ctl.issue(4'h5, 3'h2, 13'h0555);
    check(16'(dec.cmd), 16'(DCA_CMD_RD));
    check(16'(dec.col), 16'h0155);
    check(16'({dec.auto_pre, dec.burst_full}), 16'h0002);
    check(16'(bank_open), 16'h0000);
    check(16'(bank_pend_pre), 16'h0004);
    i_ctl.issue(4'h4, 3'h2, 13'h1122);
    check(16'(dec.cmd), 16'(DCA_CMD_WR));
    check(16'(dec.col), 16'h0122);
    check(16'({dec.auto_pre, dec.burst_full}), 16'h0001);
    check(16'(bank_pend_pre), 16'h0000);
    $display("test rw done");
  endtask
  task automatic t_pre();
    i_ctl.issue(4'h3, 3'h3, 13'h0000);
    i_ctl.issue(4'h3, 3'h4, 13'h0000);
    i_ctl.issue(4'h2, 3'h3, 13'h0000);
    check(16'(dec.cmd), 16'(DCA_CMD_PRE));
    check(16'({dec.pre_all, bank_open}), 16'h0010);
    i_ctl.issue(4'h3, 3'h6, 13'h0000);
    i_ctl.issue(4'h7, 3'h1, 13'h0000);
    check(16'(dec.cmd), 16'(DCA_CMD_NOP));
    check(16'(bank_open), 16'h0050);
    i_ctl.issue(4'h1, 3'h6, 13'h0400);
    check(16'(dec.cmd), 16'(DCA_CMD_OTHER));
    check(16'(bank_open), 16'h0050);
    i_ctl.issue(4'h2, 3'h0, 13'h0400);
    check(16'({dec.pre_all, bank_open}), 16'h0100);
    $display("test pre done");
  endtask
  task automatic t_mode();
    i_ctl.issue(4'h0, 3'h1, 13'h0800);
    check(16'(dec.cmd), 16'(DCA_CMD_MRS));
    check(16'(dec.opcode), 16'h0800);
    check(16'({tdqs_en, tdqs_term}), 16'h0003);
    i_ctl.beat(1'b1, 1'b1);
    check(16'(wr_strobe), 16'h0001);
    check(16'(wr_byte_en), 16'h0001);
    i_ctl.issue(4'h0, 3'h1, 13'h0000);
    check(16'(tdqs_en), 16'h0000);
    i_ctl.issue(4'h0, 3'h2, 13'h0800);
    check(16'({tdqs_en, tdqs_term}), 16'h0000);
    i_ctl.beat(1'b1, 1'b1);
    check(16'(wr_byte_en), 16'h0000);
    i_ctl.beat(1'b1, 1'b0);
    check(16'(wr_byte_en), 16'h0001);
    i_ctl.beat(1'b0, 1'b0);
    check(16'(dqs_oe), 16'h0001);
    check(16'({dqs_oe, dqs_o}), 16'h0003);
    check(16'(wr_strobe), 16'h0000);
    i_ctl.idle();
    check(16'(dqs_oe), 16'h0000);
    $display("test mode done");
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_act();
    t_rw();
    t_pre();
    t_mode();
    wrap_up();
  end
endmodule // tb
